// ==== hw/cpw_top.sv ====
// Two compare/PWM channels with their byte registers and Timer2 time base.
// Assumes Timer1 counts on mclk and clears on timer1_clear; bus on mclk.
//
// Summary of operation
// - Compare 16-bit value against Timer1 continuously
// - Mode codes pick set, clear, event, trigger
// - Mode zero resets channel; 11xx selects PWM
// - Zero control write forces compare latch low
// - Event mode leaves pin, sets event flag
// - Channel one trigger clears Timer1
// - Channel two trigger clears Timer1, starts conversion
// - Trigger clear never sets Timer1 overflow flag
// - PWM mode drives ten-bit resolution waveform
// - Zero control write forces PWM latch low
// - Timer2 period register sets PWM period
// - Period roll clears Timer2, sets pin unless duty is zero, latches duty
// - Postscaler does not affect PWM period
// - Duty is low byte plus control bits
// - Duty takes effect next period; high read-only
// - High byte plus hidden latch buffer duty
// - Pin clears when duty equals extended Timer2
// - Duty beyond period keeps pin high
// - Timer2 prescaler divides by 1, 4, 16
// - Reset clears control; values kept unchanged
`timescale 1ns/100ps
module cpw_top
	import cpw_pkg::*;
#(
	parameter int CHANNELS = 2
)
(
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic [15:0] timer1_count,
	input wire logic adc_enabled,
	output logic timer1_clear,
	output logic adc_start,
	output logic channel1_pin,
	output logic channel2_pin,
	output logic channel1_request,
	output logic channel2_request,
	output logic timer2_period_event
);

	// Timer2 configuration registers and time base signals
	logic [6:0] t2_ctrl;
	logic [7:0] t2_period;
	logic [7:0] t2_count;
	logic [1:0] t2_sub;
	logic t2_roll;
	logic t2_roll_q;
	logic t2_event;
	logic t2_count_wr;

	// Per-channel views used by the shared bus and output logic
	logic [CHANNELS-1:0][7:0] low_rd;
	logic [CHANNELS-1:0][7:0] high_rd;
	logic [CHANNELS-1:0][5:0] ctrl_rd;
	logic [CHANNELS-1:0] flag_rd;
	logic [CHANNELS-1:0] enable_rd;
	logic [CHANNELS-1:0] pin_rd;
	logic [CHANNELS-1:0] trig;
	logic [CHANNELS-1:0] request;

	logic [7:0] next_rdata;

	assign t2_count_wr = reg_wr && (reg_addr == OFS_T2_COUNT);

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			t2_ctrl <= T2_CTRL_RST;
		end else if (ce && reg_wr && (reg_addr == OFS_T2_CTRL)) begin
			t2_ctrl <= reg_wdata[6:0];
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			t2_period <= T2_PERIOD_RST;
		end else if (ce && reg_wr && (reg_addr == OFS_T2_PERIOD)) begin
			t2_period <= reg_wdata;
		end
	end

	cpw_timer2 u_timer2 (
		.mclk(mclk),
		.rst_n(rst_n),
		.ce(ce),
		.run(t2_ctrl[T2_ON_POS]),
		.prescale(t2_ctrl[T2_PRE_POS +: 2]),
		.postscale(t2_ctrl[T2_POST_POS +: 4]),
		.period(t2_period),
		.count_wr(t2_count_wr),
		.count_wdata(reg_wdata),
		.count(t2_count),
		.sub_count(t2_sub),
		.roll(t2_roll),
		.period_event(t2_event)
	);

	// Pin sets one cycle after the roll, matching the lag of the duty clear
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			t2_roll_q <= 1'b0;
		end else if (ce) begin
			t2_roll_q <= t2_roll;
		end
	end

	genvar i;
	generate
		for (i = 0; i < CHANNELS; i++) begin : chan
			logic [7:0] value_low;
			logic [7:0] value_high;
			logic [5:0] ctrl;
			logic [1:0] duty_hidden;
			logic pin;
			logic flag;
			logic enable;
			logic eq_q;
			logic cmp_eq;
			logic hit;
			logic pwm_eq;
			logic wr_low;
			logic wr_high;
			logic wr_ctrl;
			logic wr_flag;
			logic wr_enable;
			cpw_op_type op;

			assign wr_low = reg_wr && (reg_addr == OFS_LOW[i]);
			assign wr_high = reg_wr && (reg_addr == OFS_HIGH[i]);
			assign wr_ctrl = reg_wr && (reg_addr == OFS_CTRL[i]);
			assign wr_flag = reg_wr && (reg_addr == OFS_FLAGS[i]);
			assign wr_enable = reg_wr && (reg_addr == OFS_ENABLES[i]);

			// Decode of the mode field
			always_comb begin
				case (ctrl[3:0])
					MODE_CMP_SET,
					MODE_CMP_CLR,
					MODE_CMP_SOFT,
					MODE_CMP_SPECIAL: begin
						op = CPW_COMPARE;
					end
					default: begin
						if (ctrl[3:2] == MODE_PWM_TOP) begin
							op = CPW_PWM;
						end else begin
							op = CPW_IDLE;
						end
					end
				endcase
			end

			// Whole 16-bit pair against Timer1
			assign cmp_eq = ({value_high, value_low} == timer1_count);
			assign hit = (op == CPW_COMPARE) && cmp_eq && !eq_q;

			// Active duty against Timer2 extended by the sub-count
			assign pwm_eq = ({value_high, duty_hidden} == {t2_count, t2_sub});

			// Value bytes have no reset so they survive any reset
			always_ff @(posedge mclk) begin
				if (ce && wr_low) begin
					value_low <= reg_wdata;
				end
			end

			always_ff @(posedge mclk) begin
				if (ce) begin
					if (op == CPW_PWM) begin
						if (t2_roll) begin
							value_high <= value_low;
						end
					end else if (wr_high) begin
						value_high <= reg_wdata;
					end
				end
			end

			always_ff @(posedge mclk or negedge rst_n) begin
				if (!rst_n) begin
					ctrl <= CTRL_RST;
				end else if (ce && wr_ctrl) begin
					ctrl <= reg_wdata[5:0];
				end
			end

			// Hidden two low bits of the active ten-bit duty
			always_ff @(posedge mclk or negedge rst_n) begin
				if (!rst_n) begin
					duty_hidden <= 2'h0;
				end else if (ce) begin
					if (ctrl[3:0] == MODE_OFF) begin
						duty_hidden <= 2'h0;
					end else if (op == CPW_PWM && t2_roll) begin
						duty_hidden <= ctrl[DUTY_LSB_POS +: 2];
					end
				end
			end

			// One event per arrival of equality
			always_ff @(posedge mclk or negedge rst_n) begin
				if (!rst_n) begin
					eq_q <= 1'b0;
				end else if (ce) begin
					eq_q <= cmp_eq && (op == CPW_COMPARE);
				end
			end

			// Output latch shared by compare and PWM
			always_ff @(posedge mclk or negedge rst_n) begin
				if (!rst_n) begin
					pin <= 1'b0;
				end else if (ce) begin
					if (wr_ctrl && reg_wdata == 8'h00) begin
						pin <= 1'b0;
					end else if (ctrl[3:0] == MODE_OFF) begin
						pin <= 1'b0;
					end else if (op == CPW_COMPARE) begin
						if (hit && ctrl[3:0] == MODE_CMP_SET) begin
							pin <= 1'b1;
						end else if (hit && ctrl[3:0] == MODE_CMP_CLR) begin
							pin <= 1'b0;
						end
						// Event and trigger modes leave the pin as is
					end else if (op == CPW_PWM) begin
						if (t2_roll_q) begin
							pin <= ({value_high, duty_hidden} != 10'h000);
						end else if (pwm_eq) begin
							pin <= 1'b0;
						end
					end
				end
			end

			// Event flag: a hardware set wins over a software clear
			always_ff @(posedge mclk or negedge rst_n) begin
				if (!rst_n) begin
					flag <= 1'b0;
				end else if (ce) begin
					if (hit) begin
						flag <= 1'b1;
					end else if (wr_flag) begin
						flag <= reg_wdata[FLAG_POS[i]];
					end
				end
			end

			always_ff @(posedge mclk or negedge rst_n) begin
				if (!rst_n) begin
					enable <= 1'b0;
				end else if (ce && wr_enable) begin
					enable <= reg_wdata[FLAG_POS[i]];
				end
			end

			assign trig[i] = hit && (ctrl[3:0] == MODE_CMP_SPECIAL);
			assign request[i] = flag && enable;
			assign low_rd[i] = value_low;
			assign high_rd[i] = value_high;
			assign ctrl_rd[i] = ctrl;
			assign flag_rd[i] = flag;
			assign enable_rd[i] = enable;
			assign pin_rd[i] = pin;
		end
	endgenerate

	// Trigger clears only the count; overflow flag lives in Timer1
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			timer1_clear <= 1'b0;
		end else if (ce) begin
			timer1_clear <= |trig;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			adc_start <= 1'b0;
		end else if (ce) begin
			adc_start <= trig[1] && adc_enabled;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			channel1_pin <= 1'b0;
			channel2_pin <= 1'b0;
		end else if (ce) begin
			channel1_pin <= pin_rd[0];
			channel2_pin <= pin_rd[1];
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			channel1_request <= 1'b0;
			channel2_request <= 1'b0;
			timer2_period_event <= 1'b0;
		end else if (ce) begin
			channel1_request <= request[0];
			channel2_request <= request[1];
			timer2_period_event <= t2_event;
		end
	end

	// Read multiplexer; unmapped offsets read zero
	always_comb begin
		next_rdata = 8'h00;
		case (reg_addr)
			OFS_T2_COUNT: next_rdata = t2_count;
			OFS_T2_CTRL: next_rdata = {1'b0, t2_ctrl};
			OFS_T2_PERIOD: next_rdata = t2_period;
			OFS_STATUS: next_rdata = {4'h0, t2_ctrl[T2_ON_POS], t2_roll, pin_rd};
			OFS_FLAGS[0]: next_rdata[FLAG_POS[0]] = flag_rd[0];
			OFS_FLAGS[1]: next_rdata[FLAG_POS[1]] = flag_rd[1];
			OFS_ENABLES[0]: next_rdata[FLAG_POS[0]] = enable_rd[0];
			OFS_ENABLES[1]: next_rdata[FLAG_POS[1]] = enable_rd[1];
			OFS_LOW[0]: next_rdata = low_rd[0];
			OFS_LOW[1]: next_rdata = low_rd[1];
			OFS_HIGH[0]: next_rdata = high_rd[0];
			OFS_HIGH[1]: next_rdata = high_rd[1];
			OFS_CTRL[0]: next_rdata = {2'h0, ctrl_rd[0]};
			OFS_CTRL[1]: next_rdata = {2'h0, ctrl_rd[1]};
			default: next_rdata = 8'h00;
		endcase
	end

	// Read data stands only in the cycle after the strobe
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= RDATA_RST;
		end else if (ce) begin
			reg_rdata <= reg_rd ? next_rdata : RDATA_RST;
		end
	end

endmodule // cpw_top

// ==== hw/cpw_pkg.sv ====
// Constants shared by the compare/PWM unit and its Timer2 time base.
// Assumes an 8-bit register address space and byte-wide register data.
package cpw_pkg;

	// Register offsets
	localparam logic [7:0] OFS_T2_COUNT = 8'h11;
	localparam logic [7:0] OFS_T2_CTRL = 8'h12;
	localparam logic [7:0] OFS_T2_PERIOD = 8'h92;
	localparam logic [7:0] OFS_STATUS = 8'h1e;
	localparam logic [1:0][7:0] OFS_FLAGS = {8'h0d, 8'h0c};
	localparam logic [1:0][7:0] OFS_ENABLES = {8'h8d, 8'h8c};
	localparam logic [1:0][7:0] OFS_LOW = {8'h1b, 8'h15};
	localparam logic [1:0][7:0] OFS_HIGH = {8'h1c, 8'h16};
	localparam logic [1:0][7:0] OFS_CTRL = {8'h1d, 8'h17};

	// Field positions
	localparam logic [1:0][2:0] FLAG_POS = {3'd0, 3'd2};
	localparam int DUTY_LSB_POS = 4;
	localparam int T2_ON_POS = 2;
	localparam int T2_PRE_POS = 0;
	localparam int T2_POST_POS = 3;

	// Mode field codes
	localparam logic [3:0] MODE_OFF = 4'h0;
	localparam logic [3:0] MODE_CMP_SET = 4'h8;
	localparam logic [3:0] MODE_CMP_CLR = 4'h9;
	localparam logic [3:0] MODE_CMP_SOFT = 4'ha;
	localparam logic [3:0] MODE_CMP_SPECIAL = 4'hb;
	localparam logic [1:0] MODE_PWM_TOP = 2'h3;

	// Timer2 prescale codes
	localparam logic [1:0] PRE_DIV1 = 2'h0;
	localparam logic [1:0] PRE_DIV4 = 2'h1;

	// Values after reset
	localparam logic [5:0] CTRL_RST = 6'h00;
	localparam logic [6:0] T2_CTRL_RST = 7'h00;
	localparam logic [7:0] T2_PERIOD_RST = 8'hff;
	localparam logic [7:0] T2_COUNT_RST = 8'h00;
	localparam logic [7:0] RDATA_RST = 8'h00;

	typedef enum logic [1:0] {
		CPW_IDLE,
		CPW_COMPARE,
		CPW_PWM
	} cpw_op_type;

endpackage

// ==== hw/cpw_timer2.sv ====
// Timer2 time base for the PWM channels: prescaler, 8-bit count, period match.
// Assumes the same clock and clock enable as the register bus.
`timescale 1ns/100ps
module cpw_timer2
	import cpw_pkg::*;
(
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic run,
	input wire logic [1:0] prescale,
	input wire logic [3:0] postscale,
	input wire logic [7:0] period,
	input wire logic count_wr,
	input wire logic [7:0] count_wdata,
	output logic [7:0] count,
	output logic [1:0] sub_count,
	output logic roll,
	output logic period_event
);

	logic [5:0] pre;
	logic [3:0] post;
	logic tick;

	// Four clocks per increment at 1:1, times 4 or 16 above that
	always_comb begin
		case (prescale)
			PRE_DIV1: begin
				tick = run && (pre[1:0] == 2'h3);
				sub_count = pre[1:0];
			end
			PRE_DIV4: begin
				tick = run && (pre[3:0] == 4'hf);
				sub_count = pre[3:2];
			end
			default: begin
				tick = run && (pre == 6'h3f);
				sub_count = pre[5:4];
			end
		endcase
	end

	assign roll = tick && (count == period);

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			pre <= 6'h00;
		end else if (ce) begin
			if (count_wr || !run) begin
				pre <= 6'h00;
			end else begin
				pre <= pre + 6'h01;
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			count <= T2_COUNT_RST;
		end else if (ce) begin
			if (count_wr) begin
				count <= count_wdata;
			end else if (roll) begin
				count <= T2_COUNT_RST;
			end else if (tick) begin
				count <= count + 8'h01;
			end
		end
	end

	// Postscaler only paces the period event, never the count
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			post <= 4'h0;
			period_event <= 1'b0;
		end else if (ce) begin
			period_event <= roll && (post == postscale);
			if (roll) begin
				post <= (post == postscale) ? 4'h0 : post + 4'h1;
			end
		end
	end

endmodule // cpw_timer2

// ==== test/cpw_timer1_model.sv ====
// Timer1 time base and converter start counter beside cpw_top.
// Assumes the same mclk and rst_n as the unit under test.
`timescale 1ns/100ps
module cpw_timer1_model (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic clear,
	input wire logic adc_start,
	output logic [15:0] count,
	output logic overflow,
	output logic [7:0] conversions
);
	// Synchronous timer mode, counting every mclk
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			count <= 16'h0000;
			overflow <= 1'b0;
		end else if (clear) begin
			count <= 16'h0000;
		end else begin
			count <= count + 16'h0001;
			if (count == 16'hffff)
				overflow <= 1'b1;
		end
	end
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			conversions <= 8'h00;
		else if (adc_start)
			conversions <= conversions + 8'h01;
	end
endmodule // cpw_timer1_model

// ==== test/cpw_checker.sv ====
// Assertions on the cpw_top ports, bound into every instance.
// Assumes registers change only through the bus port.
`timescale 1ns/100ps
module cpw_checker
	import cpw_pkg::*;
#(
	parameter int CHANNELS = 2
)
(
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic [15:0] timer1_count,
	input wire logic adc_enabled,
	input wire logic timer1_clear,
	input wire logic adc_start,
	input wire logic channel1_pin,
	input wire logic channel2_pin,
	input wire logic channel1_request,
	input wire logic channel2_request,
	input wire logic timer2_period_event
);
	logic [15:0] val [2];
	logic [5:0] ctl [2];
	logic [1:0] eq;
	logic [1:0] hit;
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			ctl <= '{CTRL_RST, CTRL_RST};
			eq <= 2'h0;
		end else if (ce) begin
			for (int i = 0; i < 2; i++) begin
				eq[i] <= val[i] == timer1_count;
				if (reg_wr && reg_addr == OFS_LOW[i])
					val[i][7:0] <= reg_wdata;
				if (reg_wr && reg_addr == OFS_HIGH[i] && ctl[i][3:2] != MODE_PWM_TOP)
					val[i][15:8] <= reg_wdata;
				if (reg_wr && reg_addr == OFS_CTRL[i])
					ctl[i] <= reg_wdata[5:0];
			end
		end
	end
	// Arrival of equality in a compare mode
	assign hit[0] = ce && ctl[0][3:2] == 2'h2 && val[0] == timer1_count && !eq[0];
	assign hit[1] = ce && ctl[1][3:2] == 2'h2 && val[1] == timer1_count && !eq[1];
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	a_ctrl_read: assert property (ce && reg_rd && reg_addr == OFS_CTRL[0] |=> reg_rdata == {2'h0, ctl[0]})
		else $error("control read back wrong");
	a_pin_set: assert property (hit[0] && ctl[0][3:0] == MODE_CMP_SET |-> ##2 channel1_pin)
		else $error("pin not set on match");
	a_pin_clear: assert property (hit[0] && ctl[0][3:0] == MODE_CMP_CLR |-> ##2 !channel1_pin)
		else $error("pin not cleared on match");
	a_pin_kept: assert property (hit[0] && ctl[0][3:1] == 3'h5 |=> $stable(channel1_pin) [*2])
		else $error("pin moved in event mode");
	a_trig_clear: assert property (hit[0] && ctl[0][3:0] == MODE_CMP_SPECIAL |=> timer1_clear)
		else $error("no timer clear on trigger");
	a_adc_start: assert property (hit[1] && ctl[1][3:0] == MODE_CMP_SPECIAL && adc_enabled |=> adc_start)
		else $error("no conversion start");
	a_adc_paired: assert property (adc_start |-> timer1_clear)
		else $error("conversion start without clear");
	a_zero_off: assert property (ce && reg_wr && reg_addr == OFS_CTRL[0] && reg_wdata == 8'h00 |-> ##2 !channel1_pin)
		else $error("pin not low after control clear");
	cover property (hit[0]);
	cover property (adc_start);
	cover property (channel1_pin ##1 !channel1_pin);
endmodule // cpw_checker
bind cpw_top cpw_checker #(.CHANNELS(CHANNELS)) u_checker (.*);

// ==== test/testbench.sv ====
// Self-checking bench for cpw_top with a Timer1 partner model.
// Assumes ce stays high throughout.
`timescale 1ns/100ps
module testbench
	import cpw_pkg::*;
;
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic ce = 1'b1;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic adc_enabled = 1'b0;
	logic [7:0] reg_rdata;
	logic [15:0] timer1_count;
	logic timer1_clear, adc_start, channel1_pin, channel2_pin;
	logic channel1_request, channel2_request, timer2_period_event, ovf;
	logic [7:0] conv;
	int fail_count = 0;
	int comparisons = 0;
	always #25 mclk = ~mclk;
	cpw_top #(.CHANNELS(2)) dut (.*);
	cpw_timer1_model partner (.mclk(mclk), .rst_n(rst_n), .clear(timer1_clear), .adc_start(adc_start),
		.count(timer1_count), .overflow(ovf), .conversions(conv));
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fail_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge mclk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata, e);
	endtask
	task automatic wait_t1(input logic [15:0] v);
		for (int k = 0; k < 400 && timer1_count !== v; k++) begin
			@(posedge mclk);
			#1;
		end
		repeat (4) @(posedge mclk);
		#1;
	endtask
	task automatic t_regs;
		logic [7:0] a [5] = '{OFS_CTRL[0], OFS_CTRL[1], OFS_FLAGS[1], OFS_ENABLES[1], OFS_T2_PERIOD};
		logic [7:0] e [5] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hff};
		for (int i = 0; i < 5; i++)
			rd(a[i], e[i]);
		wr(OFS_CTRL[0], 8'hf0);
		rd(OFS_CTRL[0], 8'h30);
		wr(OFS_CTRL[0], 8'h00);
	endtask
	task automatic t_compare;
		logic [3:0] m [6] = '{MODE_CMP_SET, MODE_CMP_SOFT, MODE_OFF, MODE_CMP_SET, MODE_CMP_CLR, MODE_CMP_SPECIAL};
		logic p [6] = '{1, 1, 0, 1, 0, 0};
		logic [15:0] v;
		wr(OFS_ENABLES[0], 8'h04);
		for (int i = 0; i < 6; i++) begin
			v = timer1_count + 16'h0120;
			wr(OFS_LOW[0], v[7:0]);
			wr(OFS_HIGH[0], v[15:8]);
			wr(OFS_CTRL[0], {4'h0, m[i]});
			wait_t1(v - 16'h0100);
			rd(OFS_FLAGS[0], 8'h00);
			wait_t1(v);
			chk(channel1_pin, p[i]);
			chk(channel1_request, m[i] != MODE_OFF);
			rd(OFS_FLAGS[0], m[i] != MODE_OFF ? 8'h04 : 8'h00);
			if (m[i] == MODE_CMP_SPECIAL)
				chk(timer1_count < 16'h0008, 1'b1);
			wr(OFS_FLAGS[0], 8'h00);
		end
		wr(OFS_CTRL[0], 8'h00);
	endtask
	task automatic t_chan2;
		logic [15:0] v;
		logic [7:0] n;
		wr(OFS_ENABLES[1], 8'h01);
		wr(OFS_CTRL[1], {4'h0, MODE_CMP_SPECIAL});
		for (int i = 0; i < 2; i++) begin
			adc_enabled <= i == 0;
			n = conv;
			v = timer1_count + 16'h0120;
			wr(OFS_LOW[1], v[7:0]);
			wr(OFS_HIGH[1], v[15:8]);
			wait_t1(v);
			chk(conv - n, i == 0 ? 16'h1 : 16'h0);
			chk(timer1_count < 16'h0008, 1'b1);
			chk(ovf, 1'b0);
			chk(channel2_request, 1'b1);
			chk(channel2_pin, 1'b0);
			rd(OFS_FLAGS[1], 8'h01);
			wr(OFS_FLAGS[1], 8'h00);
		end
		wr(OFS_CTRL[1], 8'h00);
	endtask
	task automatic t_pwm;
		logic [1:0] pr [5] = '{PRE_DIV1, PRE_DIV1, PRE_DIV1, PRE_DIV4, 2'h2};
		logic [7:0] per [5] = '{8'h03, 8'h03, 8'h03, 8'h03, 8'h01};
		logic [9:0] d [5] = '{10'h005, 10'h000, 10'h014, 10'h008, 10'h004};
		int hi [5] = '{5, 0, 16, 32, 64};
		int len [5] = '{16, 16, 16, 64, 128};
		int n;
		for (int i = 0; i < 5; i++) begin
			wr(OFS_T2_PERIOD, per[i]);
			wr(OFS_T2_COUNT, 8'h00);
			wr(OFS_LOW[0], d[i][9:2]);
			wr(OFS_T2_CTRL, {1'b0, 4'(i), 1'b1, pr[i]});
			wr(OFS_CTRL[0], {2'h0, d[i][1:0], 4'hc});
			repeat (2 * len[i] + 8) @(posedge mclk);
			n = 0;
			repeat (len[i]) begin
				@(posedge mclk);
				#1 n += channel1_pin;
			end
			chk(16'(n), 16'(hi[i]));
			n = 0;
			repeat (len[i] * (i + 1)) begin
				@(posedge mclk);
				#1 n += timer2_period_event;
			end
			chk(16'(n), 16'h0001);
			wr(OFS_HIGH[0], 8'haa);
			rd(OFS_HIGH[0], d[i][9:2]);
		end
		wr(OFS_CTRL[0], 8'h00);
		n = 0;
		repeat (256) begin
			@(posedge mclk);
			#1 n += channel1_pin;
		end
		chk(16'(n), 16'h0000);
	endtask
	task automatic print_verdict;
		$display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial begin
		#1500000;
		fail_count++;
		print_verdict;
	end
	initial begin
		repeat (12) @(posedge mclk);
		rst_n <= 1'b1;
		t_regs;
		t_compare;
		t_chan2;
		t_pwm;
		print_verdict;
	end
endmodule // testbench
